// ===== rtl/adcsc_defines.vh
// Constants of the converter sequence control block: register indices,
// field positions, reset values and mode codes.
// Assumes inclusion by bare name from the top-level design file and the property file.
`ifndef ADCSC_DEFINES_VH
`define ADCSC_DEFINES_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define ADCSC_IDX_CTL3 8'h63
`define ADCSC_IDX_CTL4 8'h64
`define ADCSC_IDX_CTL5 8'h65
`define ADCSC_IDX_STAT0 8'h66
`define ADCSC_IDX_STAT1 8'h67

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ADCSC_RST_CTL3 8'h00
`define ADCSC_RST_CTL4 8'h01
`define ADCSC_RST_CTL5 8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ADCSC_CTL3_ONE_LEN 3
`define ADCSC_CTL3_FIFO 2
`define ADCSC_CTL3_HALT_HI 1
`define ADCSC_CTL3_HALT_LO 0
`define ADCSC_CTL4_TEN_BIT 7
`define ADCSC_CTL4_SMP_HI 6
`define ADCSC_CTL4_SMP_LO 5
`define ADCSC_CTL4_DIV_HI 4
`define ADCSC_CTL5_EIGHT_LEN 6
`define ADCSC_CTL5_CONT 5
`define ADCSC_CTL5_MULTI 4
`define ADCSC_CTL5_SPECIAL 3
`define ADCSC_CTL5_CHAN_HI 2
`define ADCSC_STAT0_SCF 7

// ----------------------------------------------------------------------
// Debug halt selection codes
// ----------------------------------------------------------------------
`define ADCSC_HALT_RUN 2'h0
`define ADCSC_HALT_RSVD 2'h1
`define ADCSC_HALT_FINISH 2'h2
`define ADCSC_HALT_NOW 2'h3

// ----------------------------------------------------------------------
// Final sample phase lengths, as last count (periods minus one)
// ----------------------------------------------------------------------
`define ADCSC_SMP_LAST_2 4'h1
`define ADCSC_SMP_LAST_4 4'h3
`define ADCSC_SMP_LAST_8 4'h7
`define ADCSC_SMP_LAST_16 4'hf

// ----------------------------------------------------------------------
// Sequence lengths, as last conversion index
// ----------------------------------------------------------------------
`define ADCSC_LEN_LAST_1 3'h0
`define ADCSC_LEN_LAST_4 3'h3
`define ADCSC_LEN_LAST_8 3'h7

`endif

// ===== rtl/adcsc_clkdiv.v
// Converter clock prescaler: modulus counter followed by a halving stage.
// Assumes the divider value is stable and restart is a one-cycle pulse.
`timescale 1ns/1ps
module adcsc_clkdiv
#(
   parameter DIV_W = 5
)
(
   input wire pclk,
   input wire presetn,
   input wire restart,
   input wire [DIV_W-1:0] divider,
   output reg adc_clk_ff,
   output reg tick_ff
);

reg [DIV_W-1:0] cnt_ff;
reg [DIV_W-1:0] nxt_cnt;
reg nxt_adc_clk;
reg nxt_tick;

// ----------------------------------------------------------------------
// Divide by N+1, then by two
// ----------------------------------------------------------------------
always @*
begin
   nxt_cnt = cnt_ff;
   nxt_adc_clk = adc_clk_ff;
   nxt_tick = 1'b0;
   if (restart)
   begin
      nxt_cnt = {DIV_W{1'b0}};
      nxt_adc_clk = 1'b0;
   end
   else if (cnt_ff >= divider)
   begin
      nxt_cnt = {DIV_W{1'b0}};
      nxt_adc_clk = ~adc_clk_ff;
      nxt_tick = ~adc_clk_ff;
   end
   else
   begin
      nxt_cnt = cnt_ff + {{(DIV_W-1){1'b0}}, 1'b1};
   end
end

// The tick marks each rising edge of the converter clock, so the
// sequencer stays on pclk and needs no second clock domain.
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      cnt_ff <= {DIV_W{1'b0}};
      adc_clk_ff <= 1'b0;
      tick_ff <= 1'b0;
   end
   else
   begin
      cnt_ff <= nxt_cnt;
      adc_clk_ff <= nxt_adc_clk;
      tick_ff <= nxt_tick;
   end
end

endmodule

// ===== rtl/adcsc_top.v
// Sequence and clock control of an eight channel converter, with APB
// access to its control and status registers.
// Assumes the analog machine runs on pclk and pulses conv_done once
// per conversion started; the debug indication arrives from a pin.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "adcsc_defines.vh"

module adcsc_top
#(
   parameter ADDR_W = 12
)
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata_ff,
   output reg pready_ff,
   output reg pslverr_ff,
   input wire background_debug_active,
   input wire conv_done,
   output wire adc_clk,
   output reg conv_start_ff,
   output reg [2:0] conv_channel_ff,
   output reg conv_special_ff,
   output reg conv_ten_bit_ff,
   output reg [2:0] result_index_ff,
   output reg sampling_ff,
   output reg conv_pause_ff,
   output reg seq_busy_ff
);

// ----------------------------------------------------------------------
// State codes
// ----------------------------------------------------------------------
localparam ST_IDLE = 4'h1;
localparam ST_LOAD = 4'h2;
localparam ST_SAMP = 4'h4;
localparam ST_CONV = 4'h8;
localparam [7:0] RST_CTL5 = `ADCSC_RST_CTL5;

// ----------------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------------
reg one_length_sel_ff;
reg fifo_mode_ff;
reg debug_halt_sel_hi_ff;
reg debug_halt_sel_lo_ff;
reg [7:0] ctl4_ff;
reg [6:0] ctl5_ff;
reg bdm_meta_ff;
reg bdm_sync_ff;
reg [3:0] state_ff;
reg [3:0] nxt_state;
reg [3:0] samp_cnt_ff;
reg [3:0] nxt_samp_cnt;
reg [2:0] conv_cnt_ff;
reg [2:0] nxt_conv_cnt;
reg [2:0] ptr_ff;
reg [2:0] nxt_ptr;
reg [2:0] chan_ff;
reg [2:0] nxt_chan;
reg sequence_complete_flag_ff;
reg nxt_scf;
reg [7:0] result_complete_flag_ff;
reg [7:0] nxt_ccf;
reg [2:0] cfg_len_last_ff;
reg [3:0] cfg_smp_last_ff;
reg [2:0] cfg_chan_ff;
reg cfg_multi_ff;
reg cfg_special_ff;
reg cfg_ten_bit_ff;
reg cfg_cont_ff;
reg nxt_conv_start;
reg [31:0] nxt_rdata;
reg nxt_slverr;
reg [2:0] len_last;
reg [3:0] smp_last;
wire [7:0] reg_idx;
wire idx_hit;
wire acc_en;
wire wr_en;
wire wr_ctl3;
wire wr_ctl4;
wire wr_ctl5;
wire new_seq;
wire div_tick;
wire [1:0] halt_sel;
wire halt_now;
wire [7:0] ctl3_rd;

// ----------------------------------------------------------------------
// APB decode
// ----------------------------------------------------------------------
assign reg_idx = paddr[9:2];
assign idx_hit = (paddr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}}) && (paddr[1:0] == 2'h0);
assign acc_en = psel & penable & pready_ff;
assign wr_en = acc_en & pwrite & ~pslverr_ff;
assign wr_ctl3 = wr_en && (reg_idx == `ADCSC_IDX_CTL3);
assign wr_ctl4 = wr_en && (reg_idx == `ADCSC_IDX_CTL4);
assign wr_ctl5 = wr_en && (reg_idx == `ADCSC_IDX_CTL5);
assign new_seq = wr_ctl4 | wr_ctl5;
assign ctl3_rd = {4'h0, one_length_sel_ff, fifo_mode_ff, debug_halt_sel_hi_ff,
                  debug_halt_sel_lo_ff};

always @*
begin
   nxt_rdata = 32'h0;
   nxt_slverr = 1'b0;
   if (!idx_hit)
   begin
      nxt_slverr = 1'b1;
   end
   else
   begin
      case (reg_idx)
         `ADCSC_IDX_CTL3:
         begin
            nxt_rdata = {24'h0, ctl3_rd};
         end
         `ADCSC_IDX_CTL4:
         begin
            nxt_rdata = {24'h0, ctl4_ff};
         end
         `ADCSC_IDX_CTL5:
         begin
            nxt_rdata = {24'h0, 1'b0, ctl5_ff};
         end
         `ADCSC_IDX_STAT0:
         begin
            nxt_rdata = {24'h0, sequence_complete_flag_ff, 4'h0, ptr_ff};
         end
         `ADCSC_IDX_STAT1:
         begin
            nxt_rdata = {24'h0, result_complete_flag_ff};
         end
         default:
         begin
            nxt_slverr = 1'b1;
         end
      endcase
   end
end

// Read data and the error answer are prepared in the setup cycle, so every
// transfer has exactly one access cycle and the bus outputs stay registered.
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0;
      pslverr_ff <= 1'b0;
   end
   else
   begin
      pready_ff <= psel & ~penable;
      if (psel && !penable)
      begin
         prdata_ff <= pwrite ? 32'h0 : nxt_rdata;
         pslverr_ff <= nxt_slverr;
      end
      else
      begin
         prdata_ff <= 32'h0;
         pslverr_ff <= 1'b0;
      end
   end
end

// ----------------------------------------------------------------------
// Control registers
// ----------------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      one_length_sel_ff <= |(`ADCSC_RST_CTL3 & (8'h01 << `ADCSC_CTL3_ONE_LEN));
      fifo_mode_ff <= 1'b0;
      debug_halt_sel_hi_ff <= 1'b0;
      debug_halt_sel_lo_ff <= 1'b0;
      ctl4_ff <= `ADCSC_RST_CTL4;
      ctl5_ff <= RST_CTL5[6:0];
   end
   else
   begin
      if (wr_ctl3)
      begin
         one_length_sel_ff <= pwdata[`ADCSC_CTL3_ONE_LEN];
         fifo_mode_ff <= pwdata[`ADCSC_CTL3_FIFO];
         debug_halt_sel_hi_ff <= pwdata[`ADCSC_CTL3_HALT_HI];
         debug_halt_sel_lo_ff <= pwdata[`ADCSC_CTL3_HALT_LO];
      end
      if (wr_ctl4)
      begin
         ctl4_ff <= pwdata[7:0];
      end
      if (wr_ctl5)
      begin
         ctl5_ff <= pwdata[6:0];
      end
   end
end

// ----------------------------------------------------------------------
// Debug indication synchroniser and halt decision
// ----------------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      bdm_meta_ff <= 1'b0;
      bdm_sync_ff <= 1'b0;
   end
   else
   begin
      bdm_meta_ff <= background_debug_active;
      bdm_sync_ff <= bdm_meta_ff;
   end
end

assign halt_sel = {debug_halt_sel_hi_ff, debug_halt_sel_lo_ff};
// Run and the reserved code never halt; finish-first only halts between
// conversions, so a conversion already started is always completed.
assign halt_now = bdm_sync_ff & ((halt_sel == `ADCSC_HALT_NOW) |
                  ((halt_sel == `ADCSC_HALT_FINISH) & (state_ff != ST_CONV)));

// ----------------------------------------------------------------------
// Converter clock
// ----------------------------------------------------------------------
adcsc_clkdiv #(
   .DIV_W(5)
) u_clkdiv (
   .pclk(pclk),
   .presetn(presetn),
   .restart(wr_ctl4),
   .divider(ctl4_ff[`ADCSC_CTL4_DIV_HI:0]),
   .adc_clk_ff(adc_clk),
   .tick_ff(div_tick)
);

// ----------------------------------------------------------------------
// Configuration decode
// ----------------------------------------------------------------------
always @*
begin
   if (ctl5_ff[`ADCSC_CTL5_EIGHT_LEN])
   begin
      len_last = `ADCSC_LEN_LAST_8;
   end
   else if (one_length_sel_ff)
   begin
      len_last = `ADCSC_LEN_LAST_1;
   end
   else
   begin
      len_last = `ADCSC_LEN_LAST_4;
   end
   case ({ctl4_ff[`ADCSC_CTL4_SMP_HI], ctl4_ff[`ADCSC_CTL4_SMP_LO]})
      2'h0: smp_last = `ADCSC_SMP_LAST_2;
      2'h1: smp_last = `ADCSC_SMP_LAST_4;
      2'h2: smp_last = `ADCSC_SMP_LAST_8;
      default: smp_last = `ADCSC_SMP_LAST_16;
   endcase
end

// The configuration, except the FIFO mode and halt select of control three, is captured
// once per initiated sequence, so continuous restarts repeat it even if control three changes meanwhile.
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      cfg_len_last_ff <= 3'h0;
      cfg_smp_last_ff <= 4'h0;
      cfg_chan_ff <= 3'h0;
      cfg_multi_ff <= 1'b0;
      cfg_special_ff <= 1'b0;
      cfg_ten_bit_ff <= 1'b0;
      cfg_cont_ff <= 1'b0;
   end
   else if (state_ff == ST_LOAD && !halt_now)
   begin
      cfg_len_last_ff <= len_last;
      cfg_smp_last_ff <= smp_last;
      cfg_chan_ff <= ctl5_ff[`ADCSC_CTL5_CHAN_HI:0];
      cfg_multi_ff <= ctl5_ff[`ADCSC_CTL5_MULTI];
      cfg_special_ff <= ctl5_ff[`ADCSC_CTL5_SPECIAL];
      cfg_ten_bit_ff <= ctl4_ff[`ADCSC_CTL4_TEN_BIT];
      cfg_cont_ff <= ctl5_ff[`ADCSC_CTL5_CONT];
   end
end

// ----------------------------------------------------------------------
// Sequencer
// ----------------------------------------------------------------------
always @*
begin
   nxt_state = state_ff;
   nxt_samp_cnt = samp_cnt_ff;
   nxt_conv_cnt = conv_cnt_ff;
   nxt_ptr = ptr_ff;
   nxt_chan = chan_ff;
   nxt_scf = sequence_complete_flag_ff;
   nxt_ccf = result_complete_flag_ff;
   nxt_conv_start = 1'b0;
   if (new_seq)
   begin
      nxt_state = ST_LOAD;
      nxt_scf = 1'b0;
      nxt_ccf = 8'h00;
   end
   // A result that ends during a freeze is still taken, or it would be lost.
   else if (halt_now && !(state_ff == ST_CONV && conv_done))
   begin
      nxt_state = state_ff;
   end
   else
   begin
      case (state_ff)
         ST_IDLE:
         begin
            nxt_state = ST_IDLE;
         end
         ST_LOAD:
         begin
            nxt_samp_cnt = 4'h0;
            nxt_conv_cnt = 3'h0;
            nxt_chan = ctl5_ff[`ADCSC_CTL5_CHAN_HI:0];
            if (!fifo_mode_ff)
            begin
               nxt_ptr = 3'h0;
            end
            nxt_state = ST_SAMP;
         end
         ST_SAMP:
         begin
            if (div_tick)
            begin
               if (samp_cnt_ff == cfg_smp_last_ff)
               begin
                  nxt_samp_cnt = 4'h0;
                  nxt_conv_start = 1'b1;
                  nxt_state = ST_CONV;
               end
               else
               begin
                  nxt_samp_cnt = samp_cnt_ff + 4'h1;
               end
            end
         end
         ST_CONV:
         begin
            if (conv_done)
            begin
               nxt_ccf[ptr_ff] = 1'b1;
               nxt_ptr = ptr_ff + 3'h1;
               nxt_conv_cnt = conv_cnt_ff + 3'h1;
               nxt_chan = cfg_multi_ff ? chan_ff + 3'h1 : chan_ff;
               nxt_state = ST_SAMP;
               if (conv_cnt_ff == cfg_len_last_ff)
               begin
                  nxt_scf = 1'b1;
                  nxt_conv_cnt = 3'h0;
                  nxt_chan = cfg_chan_ff;
                  if (!fifo_mode_ff)
                  begin
                     nxt_ptr = 3'h0;
                  end
                  nxt_state = cfg_cont_ff ? ST_SAMP : ST_IDLE;
               end
            end
         end
         default:
         begin
            nxt_state = ST_IDLE;
         end
      endcase
   end
end

always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      state_ff <= ST_IDLE;
      samp_cnt_ff <= 4'h0;
      conv_cnt_ff <= 3'h0;
      ptr_ff <= 3'h0;
      chan_ff <= 3'h0;
      sequence_complete_flag_ff <= 1'b0;
      result_complete_flag_ff <= 8'h00;
   end
   else
   begin
      state_ff <= nxt_state;
      samp_cnt_ff <= nxt_samp_cnt;
      conv_cnt_ff <= nxt_conv_cnt;
      ptr_ff <= nxt_ptr;
      chan_ff <= nxt_chan;
      sequence_complete_flag_ff <= nxt_scf;
      result_complete_flag_ff <= nxt_ccf;
   end
end

// ----------------------------------------------------------------------
// Outputs to the analog machine
// ----------------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      conv_start_ff <= 1'b0;
      conv_channel_ff <= 3'h0;
      conv_special_ff <= 1'b0;
      conv_ten_bit_ff <= 1'b0;
      result_index_ff <= 3'h0;
      sampling_ff <= 1'b0;
      conv_pause_ff <= 1'b0;
      seq_busy_ff <= 1'b0;
   end
   else
   begin
      conv_start_ff <= nxt_conv_start;
      conv_channel_ff <= nxt_chan;
      conv_special_ff <= cfg_special_ff;
      conv_ten_bit_ff <= cfg_ten_bit_ff;
      result_index_ff <= nxt_ptr;
      sampling_ff <= (nxt_state == ST_SAMP);
      conv_pause_ff <= halt_now & ~new_seq;
      seq_busy_ff <= (nxt_state != ST_IDLE);
   end
end

endmodule

// ===== test/adcsc_properties.sv
// Concurrent checks on the ports of the converter sequence control block.
// Assumes it is bound to adcsc_top and software keeps the divider code at one or more.
`timescale 1ns/1ps
`include "adcsc_defines.vh"
module adcsc_properties
#(
   parameter ADDR_W = 12
)
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata_ff,
   input wire pready_ff,
   input wire pslverr_ff,
   input wire background_debug_active,
   input wire conv_done,
   input wire adc_clk,
   input wire conv_start_ff,
   input wire [2:0] conv_channel_ff,
   input wire conv_special_ff,
   input wire conv_ten_bit_ff,
   input wire [2:0] result_index_ff,
   input wire sampling_ff,
   input wire conv_pause_ff,
   input wire seq_busy_ff
);
   wire wr_acc = psel & penable & pready_ff & pwrite;
   wire wr4 = wr_acc & (paddr[9:2] == `ADCSC_IDX_CTL4);
   wire wr45 = wr4 | (wr_acc & (paddr[9:2] == `ADCSC_IDX_CTL5));
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   setup_answer_a: assert property (psel && !penable |=> pready_ff)
      else $error("access cycle did not follow setup");
   ready_single_a: assert property (pready_ff |-> psel && penable ##1 !pready_ff)
      else $error("ready outside a single access cycle");
   seq_start_a: assert property (wr45 && !background_debug_active |-> ##[1:3] sampling_ff)
      else $error("control write did not start sampling");
   abort_quiet_a: assert property (wr45 |-> ##2 !conv_start_ff [*3])
      else $error("conversion started right after a control write");
   start_pulse_a: assert property (conv_start_ff |=> !conv_start_ff)
      else $error("start pulse longer than one cycle");
   debug_quiet_a: assert property (!background_debug_active [*5] |-> !conv_pause_ff)
      else $error("pause held without debug");
   frozen_start_a: assert property (conv_pause_ff && $past(conv_pause_ff) |-> !conv_start_ff)
      else $error("conversion started while frozen");
   ptr_cause_a: assert property ($changed(result_index_ff) |->
      $past(conv_done) || $past(wr45) || $past(wr45, 2))
      else $error("result pointer moved without cause");
   adc_half_a: assert property ($rose(adc_clk) && !wr4 |=> adc_clk)
      else $error("converter clock high for a single cycle");
   ctl5_read_a: assert property (pready_ff && !pwrite && paddr[9:2] == `ADCSC_IDX_CTL5
      |-> prdata_ff[31:7] == 25'h0)
      else $error("control five read with upper bits set");
   cover property (wr45);
   cover property (conv_start_ff && conv_channel_ff == 3'h7);
   cover property (conv_pause_ff);
endmodule
bind adcsc_top adcsc_properties #(.ADDR_W(ADDR_W)) props_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
   .pslverr_ff(pslverr_ff), .background_debug_active(background_debug_active),
   .conv_done(conv_done), .adc_clk(adc_clk), .conv_start_ff(conv_start_ff),
   .conv_channel_ff(conv_channel_ff), .conv_special_ff(conv_special_ff),
   .conv_ten_bit_ff(conv_ten_bit_ff), .result_index_ff(result_index_ff),
   .sampling_ff(sampling_ff), .conv_pause_ff(conv_pause_ff), .seq_busy_ff(seq_busy_ff));

// ===== test/adcsc_conv_model.sv
// Behavioural analog conversion machine that answers each start pulse.
// Assumes start is a one-cycle pulse on pclk; a ten-bit conversion takes longer.
`timescale 1ns/1ps
module adcsc_conv_model
(
   input wire pclk,
   input wire presetn,
   input wire conv_start,
   input wire ten_bit,
   output reg conv_done_ff
);
   reg [4:0] cnt_ff;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_ff <= 5'h00;
         conv_done_ff <= 1'b0;
      end
      else
      begin
         conv_done_ff <= (cnt_ff == 5'h01);
         if (conv_start)
            cnt_ff <= ten_bit ? 5'h0a : 5'h08;
         else if (cnt_ff != 5'h00)
            cnt_ff <= cnt_ff - 5'h01;
      end
   end
endmodule

// ===== test/adc_sequence_control_tb.sv
// Self-checking bench of the converter sequence control block.
// Assumes the design and the conversion machine model are compiled before it.
`timescale 1ns/1ps
module adc_sequence_control_tb;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0;
   reg background_debug_active = 1'b0;
   wire [31:0] prdata_ff;
   wire pready_ff, pslverr_ff, conv_done, adc_clk, conv_start_ff, conv_special_ff;
   wire conv_ten_bit_ff, sampling_ff, conv_pause_ff, seq_busy_ff;
   wire [2:0] conv_channel_ff, result_index_ff;
   int err_total = 0;
   int comparisons = 0;
   int n, smp, w, k, h, l, p, q;
   logic [31:0] rd;
   logic err;
   logic [7:0] c4, c5;
   logic [2:0] ch [16];
   logic [31:0] rows [4] = '{32'h00011004, 32'h08211501, 32'h08425708, 32'h00e10b04};
   logic [31:0] fexp [3] = '{32'h84, 32'h80, 32'h81};
   adcsc_top #(.ADDR_W(12)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
      .background_debug_active(background_debug_active), .conv_done(conv_done),
      .adc_clk(adc_clk), .conv_start_ff(conv_start_ff), .conv_channel_ff(conv_channel_ff),
      .conv_special_ff(conv_special_ff), .conv_ten_bit_ff(conv_ten_bit_ff),
      .result_index_ff(result_index_ff), .sampling_ff(sampling_ff),
      .conv_pause_ff(conv_pause_ff), .seq_busy_ff(seq_busy_ff));
   adcsc_conv_model model (.pclk(pclk), .presetn(presetn), .conv_start(conv_start_ff),
      .ten_bit(conv_ten_bit_ff), .conv_done_ff(conv_done));
   always #12.5 pclk = ~pclk;
   task chk(input string name, input [31:0] seen, input [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task tally_and_finish;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Holds the request until ready is sampled high, as the bus demands.
   task apb(input bit wr, input [7:0] idx, input [7:0] wd);
      int t;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin @(posedge pclk); t++; end while (pready_ff !== 1'b1 && t < 50);
      rd = prdata_ff;
      err = pslverr_ff;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Counts start pulses until the sequencer idles or maxn starts were seen.
   task go(input int maxn);
      int t;
      n = 0;
      smp = 0;
      t = 0;
      while ((t < 3 || seq_busy_ff === 1'b1) && n < maxn && t < 20000)
      begin
         @(posedge pclk);
         t++;
         if (sampling_ff === 1'b1 && n == 0) smp++;
         if (conv_start_ff === 1'b1)
         begin
            ch[n] = conv_channel_ff;
            n++;
         end
      end
   endtask
   initial
   begin
      #(25 * 40000);
      err_total++;
      tally_and_finish;
   end
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         apb(0, 8'h63 + i[7:0], 8'h00);
         chk("reset_value", rd, (i == 1) ? 32'h1 : 32'h0);
      end
      apb(0, 8'h10, 8'h00);
      chk("unmapped", {rd[30:0], err}, 32'h1);
      foreach (rows[r])
      begin
         c4 = rows[r][23:16];
         c5 = rows[r][15:8];
         apb(1, 8'h63, rows[r][31:24]);
         apb(1, 8'h64, c4);
         apb(1, 8'h65, c5);
         go(16);
         chk("seq_len", n, rows[r][7:0]);
         for (int i = 0; i < n; i++)
            chk("channel", ch[i], c5[4] ? 3'(c5[2:0] + i[2:0]) : c5[2:0]);
         p = 2 * (c4[4:0] + 1);
         q = 2 << c4[6:5];
         chk("sample_len", (smp >= (q - 1) * p) && (smp <= q * p + 2), 1);
         chk("latched_cfg", {conv_ten_bit_ff, conv_special_ff}, {c4[7], c5[3]});
         apb(0, 8'h66, 8'h00);
         chk("seq_done", rd, 32'h80);
         apb(0, 8'h67, 8'h00);
         chk("result_flags", rd, (32'h1 << rows[r][7:0]) - 1);
      end
      apb(1, 8'h65, 8'hc0);
      apb(0, 8'h65, 8'h00);
      chk("ctl5_read", rd, 32'h40);
      go(2);
      apb(1, 8'h65, 8'h02);
      apb(0, 8'h67, 8'h00);
      chk("flags_cleared", rd, 32'h0);
      go(16);
      chk("abort_restart", {n[7:0], 5'h0, ch[3]}, {8'h4, 8'h2});
      apb(1, 8'h64, 8'h01);
      for (int c = 0; c < 4; c++)
      begin
         apb(1, 8'h63, c[7:0]);
         apb(1, 8'h65, 8'h00);
         go(1);
         background_debug_active <= 1'b1;
         w = 0;
         for (k = 0; k < 60; k++)
         begin
            @(posedge pclk);
            if (k > 4 && conv_start_ff === 1'b1) w++;
            if (k == 50) rd = conv_pause_ff;
         end
         background_debug_active <= 1'b0;
         go(16);
         chk("frozen", w == 0, c[1]);
         chk("paused", rd, c[1]);
         chk("resumed", 1 + w + n, 4);
         apb(0, 8'h67, 8'h00);
         chk("resume_flags", rd, 32'h0f);
      end
      apb(1, 8'h63, 8'h00);
      apb(1, 8'h65, 8'h34);
      go(9);
      chk("cont_starts", {n[7:0], 5'h0, ch[4], 5'h0, ch[5]}, 24'h090405);
      apb(0, 8'h66, 8'h00);
      chk("cont_flag", {rd[7], seq_busy_ff}, 2'b11);
      apb(1, 8'h65, 8'h10);
      go(16);
      for (int j = 0; j < 3; j++)
      begin
         apb(1, 8'h63, (j == 2) ? 8'h0c : 8'h04);
         apb(1, 8'h65, 8'h10);
         go(16);
         apb(0, 8'h66, 8'h00);
         chk("fifo_ptr", rd, fexp[j]);
      end
      apb(1, 8'h65, 8'h34);
      go(1);
      presetn <= 1'b0;
      @(posedge pclk);
      chk("reset_mid", {result_index_ff, seq_busy_ff}, 4'h0);
      presetn <= 1'b1;
      apb(0, 8'h64, 8'h00);
      chk("reset_ctl4", rd, 32'h1);
      apb(0, 8'h65, 8'h00);
      chk("reset_ctl5", rd, 32'h0);
      // Divider code seven is used here; code 31 is the slowest that the five-bit field holds.
      apb(1, 8'h64, 8'h07);
      @(posedge pclk);
      k = 0;
      while (adc_clk !== 1'b1 && k < 40) begin @(posedge pclk); k++; end
      h = 0;
      while (adc_clk === 1'b1 && h < 40) begin @(posedge pclk); h++; end
      l = 0;
      while (adc_clk !== 1'b1 && l < 40) begin @(posedge pclk); l++; end
      chk("adc_half", {h[7:0], l[7:0]}, 16'h0808);
      tally_and_finish;
   end
endmodule
